//--- fdc_defs.svh
/*
  Offsets, field positions, reset values and fixed figures for the data-flash
  protection, command-object and ECC capture register block.
  Assumes a 32-bit classic Wishbone bus with byte addresses; each register
  takes one aligned word, and narrower registers sit in the low bits.
*/
// Overview of operation
// (R1) Double fault at reset load: fully protect
// (R2) Protected program/erase refused, violation flag set
// (R3) Block erase refused if anything protected
// (R4) Open bit 7: 0 protects, 1 unprotects
// (R5) Range 0x10_0000, length (size+1)*256 bytes
// (R6) Six 16-bit words, 3-bit index, bytewise
// (R7) Write 1 clears complete flag, launches
// (R8) Command words locked while command runs
// (R9) Results readable once complete flag returns
// (R10) Index 110/111 ignore writes, read zero
// (R11) Word layout: code, address, four data
// (R12) Reserved register at 0x000C reads zero
// (R13) Second reserved register reads zero
// (R14) No new capture until fault flag cleared
// (R15) Double fault wins over single fault
// (R16) ECC result window is read-only
// (R17) Index 000: parity, zero, address high bits
// (R18) Program flash: address low, four data words
// (R19) Data flash: address low, one data word
// (R20) ECC index 110/111 read zero
// (R21) Data-flash parity top two bits zero
// (R22) Captured values are uncorrected raw data
// (R23) Protection writes may only add protection
// (R24) Protection loaded from config byte at reset
// (R25) Size ignored while protection open
// (R26) Command writes ignored while command runs
`ifndef FDC_DEFS_SVH
`define FDC_DEFS_SVH

// Register byte offsets
`define FDC_OFS_CMD_IDX 8'h00
`define FDC_OFS_ECC_IDX 8'h04
`define FDC_OFS_STATUS 8'h08
`define FDC_OFS_RSV_A 8'h0c
`define FDC_OFS_DPROT 8'h10
`define FDC_OFS_CMD_WIN 8'h14
`define FDC_OFS_RSV_B 8'h18
`define FDC_OFS_ECC_WIN 8'h1c
`define FDC_OFS_ECC_FLAGS 8'h20

// Field positions
`define FDC_ST_COMMAND_COMPLETE_FLAG 7
`define FDC_ST_VIOL 5
`define FDC_DP_OPEN 7
`define FDC_EF_SGL 0
`define FDC_EF_DBL 1
`define FDC_EF_DF 2

// Reset values and fixed figures
`define FDC_DP_SIZE_FULL 5'h1f
`define FDC_DF_BASE 23'h10_0000
`define FDC_CFG_DPROT_ADDR 23'h7f_ff0d
`define FDC_CMD_WORDS 6
`define FDC_IDX_LAST 3'h5

`endif

//--- fdc_pkg.sv
/*
  Types shared by the register block: grouped input carriers and the state.
  Assumes the constants of fdc_defs.svh.
*/
package fdc_pkg;

  // Fault report from the array read path, raw and uncorrected
  typedef struct packed {
    logic sgl;
    logic dbl;
    logic is_df;
    logic [22:0] addr;
    logic [7:0] par;
    logic [63:0] data;
  } fdc_ecc_evt_t;

  // Program or erase request for a protection decision
  typedef struct packed {
    logic valid;
    logic blk_erase;
    logic [22:0] addr;
  } fdc_pe_req_t;

  // Protection byte fetched during the reset sequence
  typedef struct packed {
    logic valid;
    logic dbl_fault;
    logic [7:0] byte_v;
  } fdc_cfg_t;

  // Return word written by the memory controller
  typedef struct packed {
    logic we;
    logic [2:0] idx;
    logic [15:0] data;
  } fdc_ret_t;

  // Whole state of the block
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [2:0] cmd_idx;
    logic [2:0] ecc_idx;
    logic command_complete_flag;
    logic viol;
    logic launch;
    logic cfg_done;
    logic dp_open;
    logic [4:0] dp_size;
    logic [5:0][15:0] cmd;
    logic ef_sgl;
    logic ef_dbl;
    logic ecc_df;
    logic [22:0] ecc_addr;
    logic [7:0] ecc_par;
    logic [63:0] ecc_data;
    logic pe_ack;
    logic pe_deny;
  } fdc_state_t;

endpackage

//--- fdc_regs.sv
/*
  Register block of the embedded flash controller: data-flash protection,
  command-object array with launch handshake, ECC fault capture, reserved
  words. Assumes a classic Wishbone master, a memory controller on the same
  clock that pulses done after each launch, and a reset-sequence fetch of
  the protection byte presented once on cfg_i.
*/
`timescale 1ns/10ps
`include "fdc_defs.svh"

module fdc_regs
  import fdc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // Reset-sequence protection load
  input wire fdc_cfg_t cfg_i,
  // Memory controller command handshake
  output logic ctl_launch_o,
  output logic [95:0] ctl_cmd_o,
  input wire logic ctl_done_i,
  input wire fdc_ret_t ctl_ret_i,
  // Protection decision
  input wire fdc_pe_req_t pe_req_i,
  output logic pe_ack_o,
  output logic pe_deny_o,
  // ECC fault report
  input wire fdc_ecc_evt_t ecc_i
);

  // Refuse an address bus too narrow for the map
  if (ADDR_W < 6) begin : g_bad_addr
    $error("fdc_regs: ADDR_W must be at least 6");
  end

  fdc_state_t s_reg;
  fdc_state_t s_next;

  logic req;
  logic wr;
  logic [7:0] ofs;
  logic in_prot;
  logic [22:0] df_top;
  logic [4:0] wsize;
  logic [15:0] word_wr;
  logic [15:0] ecc_word;
  logic [31:0] rd_val;

  // Bus request decode; ack low keeps each request to one answer
  assign req = wb_cyc_i & wb_stb_i & ~s_reg.ack;
  assign wr = req & wb_we_i;
  assign ofs = 8'(wb_adr_i);
  assign wsize = wb_dat_i[4:0];

  // Protected window end; size only matters while closed [R5] [R25]
  assign df_top = `FDC_DF_BASE + {9'h000, 6'({1'b0, s_reg.dp_size} + 6'h01), 8'h00};
  assign in_prot = ~s_reg.dp_open & (pe_req_i.addr >= `FDC_DF_BASE) & (pe_req_i.addr < df_top);

  // Byte-lane merge into the selected command word [R6]
  always_comb begin
    word_wr = s_reg.cmd[s_reg.cmd_idx];
    if (wb_sel_i[0]) begin
      word_wr[7:0] = wb_dat_i[7:0];
    end
    if (wb_sel_i[1]) begin
      word_wr[15:8] = wb_dat_i[15:8];
    end
  end

  // ECC window read mux [R17] [R18] [R19] [R20] [R21]
  always_comb begin
    unique case (s_reg.ecc_idx)
      3'h0: ecc_word = {s_reg.ecc_par, 1'b0, s_reg.ecc_addr[22:16]};
      3'h1: ecc_word = s_reg.ecc_addr[15:0];
      3'h2: ecc_word = s_reg.ecc_data[15:0];
      3'h3: ecc_word = s_reg.ecc_data[31:16];
      3'h4: ecc_word = s_reg.ecc_data[47:32];
      3'h5: ecc_word = s_reg.ecc_data[63:48];
      default: ecc_word = 16'h0000;
    endcase
  end

  // Register read mux; unmapped words answer zero
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (ofs)
      `FDC_OFS_CMD_IDX: rd_val[2:0] = s_reg.cmd_idx;
      `FDC_OFS_ECC_IDX: rd_val[2:0] = s_reg.ecc_idx;
      `FDC_OFS_STATUS: begin
        rd_val[`FDC_ST_COMMAND_COMPLETE_FLAG] = s_reg.command_complete_flag;
        rd_val[`FDC_ST_VIOL] = s_reg.viol;
      end
      `FDC_OFS_RSV_A: rd_val = 32'h0000_0000; // [R12]
      `FDC_OFS_DPROT: begin
        rd_val[`FDC_DP_OPEN] = s_reg.dp_open; // [R4]
        rd_val[4:0] = s_reg.dp_size;
      end
      `FDC_OFS_CMD_WIN: begin
        // Index 110/111 have no storage [R10] [R9]
        if (s_reg.cmd_idx <= `FDC_IDX_LAST) begin
          rd_val[15:0] = s_reg.cmd[s_reg.cmd_idx];
        end
      end
      `FDC_OFS_RSV_B: rd_val = 32'h0000_0000; // [R13]
      `FDC_OFS_ECC_WIN: rd_val[15:0] = ecc_word;
      `FDC_OFS_ECC_FLAGS: begin
        rd_val[`FDC_EF_SGL] = s_reg.ef_sgl;
        rd_val[`FDC_EF_DBL] = s_reg.ef_dbl;
        rd_val[`FDC_EF_DF] = s_reg.ecc_df;
      end
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // Next-state logic for the whole block
  always_comb begin
    s_next = s_reg;
    s_next.ack = req;
    s_next.launch = 1'b0;
    s_next.pe_ack = 1'b0;
    if (req & ~wb_we_i) begin
      s_next.rdata = rd_val;
    end

    // Index registers
    if (wr & wb_sel_i[0] & (ofs == `FDC_OFS_CMD_IDX)) begin
      s_next.cmd_idx = wb_dat_i[2:0];
    end
    if (wr & wb_sel_i[0] & (ofs == `FDC_OFS_ECC_IDX)) begin
      s_next.ecc_idx = wb_dat_i[2:0];
    end

    // Command word writes only while idle and in range [R8] [R26] [R10] [R11]
    if (wr & s_reg.command_complete_flag & (ofs == `FDC_OFS_CMD_WIN) && s_reg.cmd_idx <= `FDC_IDX_LAST) begin
      s_next.cmd[s_reg.cmd_idx] = word_wr;
    end

    // Protection may only grow; each field checked alone [R23]
    if (wr & wb_sel_i[0] & (ofs == `FDC_OFS_DPROT)) begin
      if (wsize > s_reg.dp_size) begin
        s_next.dp_size = wsize;
      end
      if (~wb_dat_i[`FDC_DP_OPEN]) begin
        s_next.dp_open = 1'b0;
      end
    end

    // One-time load of the protection byte in the reset sequence [R24]
    if (cfg_i.valid & ~s_reg.cfg_done) begin
      s_next.cfg_done = 1'b1;
      if (cfg_i.dbl_fault) begin
        s_next.dp_open = 1'b0; // [R1]
        s_next.dp_size = `FDC_DP_SIZE_FULL;
      end else begin
        s_next.dp_open = cfg_i.byte_v[`FDC_DP_OPEN];
        s_next.dp_size = cfg_i.byte_v[4:0];
      end
    end

    // Violation flag: write 1 clears, a new refusal wins
    if (wr & wb_sel_i[0] & (ofs == `FDC_OFS_STATUS) & wb_dat_i[`FDC_ST_VIOL]) begin
      s_next.viol = 1'b0;
    end

    // Launch: write 1 to complete flag clears it [R7]
    if (wr & wb_sel_i[0] & (ofs == `FDC_OFS_STATUS) & wb_dat_i[`FDC_ST_COMMAND_COMPLETE_FLAG] & s_reg.command_complete_flag) begin
      s_next.command_complete_flag = 1'b0;
      s_next.launch = 1'b1;
    end

    // Results land in the array while the command runs [R9]
    if (~s_reg.command_complete_flag & ctl_ret_i.we && ctl_ret_i.idx <= `FDC_IDX_LAST) begin
      s_next.cmd[ctl_ret_i.idx] = ctl_ret_i.data;
    end
    if (~s_reg.command_complete_flag & ctl_done_i) begin
      s_next.command_complete_flag = 1'b1; // [R8]
    end

    // Protection decision, answered one cycle later
    if (pe_req_i.valid) begin
      s_next.pe_ack = 1'b1;
      // Block erase needs every sector open [R3]; others by range [R2]
      s_next.pe_deny = pe_req_i.blk_erase ? ~s_reg.dp_open : in_prot;
      if (pe_req_i.blk_erase ? ~s_reg.dp_open : in_prot) begin
        s_next.viol = 1'b1; // [R2]
      end
    end

    // ECC flags: write 1 clears; a fault below is captured only if no flag was already held
    if (wr & wb_sel_i[0] & (ofs == `FDC_OFS_ECC_FLAGS)) begin
      if (wb_dat_i[`FDC_EF_SGL]) begin
        s_next.ef_sgl = 1'b0;
      end
      if (wb_dat_i[`FDC_EF_DBL]) begin
        s_next.ef_dbl = 1'b0;
      end
    end

    // Capture only when no fault is held [R14]; raw data kept [R22]
    if ((ecc_i.sgl | ecc_i.dbl) & ~s_reg.ef_sgl & ~s_reg.ef_dbl) begin
      s_next.ef_dbl = ecc_i.dbl; // [R15]
      s_next.ef_sgl = ~ecc_i.dbl;
      s_next.ecc_df = ecc_i.is_df;
      s_next.ecc_addr = ecc_i.addr;
      if (ecc_i.is_df) begin
        // Data flash: six parity bits, one word [R21] [R19]
        s_next.ecc_par = {2'b00, ecc_i.par[5:0]};
        s_next.ecc_data = {48'h0000_0000_0000, ecc_i.data[15:0]};
      end else begin
        s_next.ecc_par = ecc_i.par; // [R18]
        s_next.ecc_data = ecc_i.data;
      end
    end
    // ECC window writes fall through with no effect [R16]
  end

  // State register; reset closes protection until the byte is loaded
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
      s_reg.command_complete_flag <= 1'b1;
      s_reg.dp_size <= `FDC_DP_SIZE_FULL;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign wb_ack_o = s_reg.ack;
  assign wb_dat_o = s_reg.rdata;
  assign ctl_launch_o = s_reg.launch;
  assign ctl_cmd_o = s_reg.cmd;
  assign pe_ack_o = s_reg.pe_ack;
  assign pe_deny_o = s_reg.pe_deny;

endmodule

//--- fdc_regs_props.sv
/*
  Checker for fdc_regs: bus answer, launch cause and lock, protection query.
  Assumes it sees only the top ports and is attached by the bind below.
*/
`timescale 1ns/10ps
module fdc_regs_props
  import fdc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  // Protection load and controller
  input wire fdc_cfg_t cfg_i,
  input wire logic ctl_launch_o,
  input wire logic [95:0] ctl_cmd_o,
  input wire logic ctl_done_i,
  input wire fdc_ret_t ctl_ret_i,
  // Protection query and ECC
  input wire fdc_pe_req_t pe_req_i,
  input wire logic pe_ack_o,
  input wire logic pe_deny_o,
  input wire fdc_ecc_evt_t ecc_i
);
  logic take_reg, we_reg, d7_reg, busy_reg;
  logic [ADDR_W-1:0] adr_reg;

  // Request taken last edge; registers avoid $past of expressions
  always_ff @(posedge clk_i) begin
    take_reg <= wb_cyc_i && wb_stb_i && !wb_ack_o && !rst_i;
    we_reg <= wb_we_i;
    adr_reg <= wb_adr_i;
    d7_reg <= wb_dat_i[7] && wb_sel_i[0];
    busy_reg <= !rst_i && (ctl_launch_o || (busy_reg && !ctl_done_i));
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_ack_answer; take_reg |-> wb_ack_o; endproperty
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  property p_launch_cause; ctl_launch_o |-> take_reg && we_reg && adr_reg == 8'h08 && d7_reg;
  endproperty
  property p_launch_once; ctl_launch_o |-> !busy_reg; endproperty
  property p_cmd_lock; busy_reg && !ctl_ret_i.we |=> $stable(ctl_cmd_o); endproperty
  property p_pe_ack; pe_ack_o == $past(pe_req_i.valid); endproperty
  property p_deny_out;
    pe_req_i.valid && !pe_req_i.blk_erase && (pe_req_i.addr < 23'h10_0000 ||
      pe_req_i.addr >= 23'h10_2000) |=> !pe_deny_o;
  endproperty
  property p_rsv_zero;
    wb_ack_o && !we_reg && (adr_reg == 8'h0c || adr_reg == 8'h18) |-> wb_dat_o == 32'h0;
  endproperty

  a_ack_answer: assert property (p_ack_answer) else $error("late ack");
  a_ack_pulse: assert property (p_ack_pulse) else $error("long ack");
  a_launch_cause: assert property (p_launch_cause) else $error("stray launch");
  a_launch_once: assert property (p_launch_once) else $error("launch while busy");
  a_cmd_lock: assert property (p_cmd_lock) else $error("command changed");
  a_pe_ack: assert property (p_pe_ack) else $error("query answer");
  a_deny_out: assert property (p_deny_out) else $error("deny out of range");
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved nonzero");

  // Main scenarios reached
  c_launch: cover property (ctl_launch_o);
  c_deny: cover property (pe_ack_o && pe_deny_o);
  c_done: cover property (busy_reg && ctl_done_i);
endmodule

bind fdc_regs fdc_regs_props #(.ADDR_W(ADDR_W)) u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_dat_o, .cfg_i, .ctl_launch_o,
  .ctl_cmd_o, .ctl_done_i, .ctl_ret_i, .pe_req_i, .pe_ack_o, .pe_deny_o, .ecc_i);

//--- test_flash_dprot_cmdobj_ecc_regs.sv
/*
  Self-checking bench for fdc_regs: commands, ECC capture, protection.
  Assumes the checker file binds itself to the design.
*/
`timescale 1ns/10ps
module test_flash_dprot_cmdobj_ecc_regs
  import fdc_pkg::*;
  ();
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, ctl_done_i = 0;
  logic [7:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o, rq;
  fdc_cfg_t cfg_i = '0;
  fdc_ret_t ctl_ret_i = '0;
  fdc_pe_req_t pe_req_i = '0;
  fdc_ecc_evt_t ecc_i = '0;
  logic [95:0] ctl_cmd_o;
  logic wb_ack_o, ctl_launch_o, pe_ack_o, pe_deny_o;
  int fails = 0, comparisons = 0;
  int launches = 0;

  fdc_regs #(.ADDR_W(8)) DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_dat_o, .cfg_i, .ctl_launch_o, .ctl_cmd_o,
    .ctl_done_i, .ctl_ret_i, .pe_req_i, .pe_ack_o, .pe_deny_o, .ecc_i);

  // 200 MHz clock
  initial forever #2.5 clk_i = ~clk_i;

  // Launch pulses seen; a second one while busy would be a stray launch
  always @(posedge clk_i) begin
    if (ctl_launch_o === 1'b1) begin
      launches <= launches + 1;
    end
  end

  task automatic give_verdict;
    if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // Classic cycle; request held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, d, s};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      fails++;
      $display("Error at %0t: no bus answer", $time);
    end
    rq = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hf);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    wb(1'b0, a, 32'h0, 4'hf);
    chk(rq & m, e);
  endtask

  // Query answered one cycle after it is taken
  task automatic pq(input logic b, input logic [22:0] a, input logic e);
    pe_req_i <= {1'b1, b, a};
    @(posedge clk_i);
    pe_req_i.valid <= 1'b0;
    @(posedge clk_i);
    chk({pe_ack_o, pe_deny_o}, {1'b1, e});
  endtask

  task automatic do_reset(input logic [7:0] b, input logic f);
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    cfg_i <= {1'b1, f, b};
    @(posedge clk_i);
    cfg_i <= '0;
    @(posedge clk_i);
  endtask

  task automatic ev(input fdc_ecc_evt_t e);
    ecc_i <= e;
    @(posedge clk_i);
    ecc_i <= '0;
    @(posedge clk_i);
  endtask

  task automatic t_cmd;
    wr(8'h0c, 32'hff);
    rd(8'h0c, 32'h0);
    wr(8'h18, 32'hff);
    rd(8'h18, 32'h0);
    rd(8'h3c, 32'h0);
    wr(8'h00, 32'h6);
    wr(8'h14, 32'hffff);
    rd(8'h14, 32'h0);
    wr(8'h00, 32'h0);
    wb(1'b1, 8'h14, 32'h1234, 4'h3);
    wb(1'b1, 8'h14, 32'h77ab, 4'h1);
    wr(8'h08, 32'h80);
    rd(8'h08, 32'h0, 32'h80);
    chk(ctl_cmd_o[15:0], 32'h12ab);
    wr(8'h14, 32'h5555);
    wr(8'h08, 32'h80);
    ctl_ret_i <= {1'b1, 3'h2, 16'hbeef};
    @(posedge clk_i);
    ctl_ret_i <= '0;
    ctl_done_i <= 1'b1;
    @(posedge clk_i);
    ctl_done_i <= 1'b0;
    @(posedge clk_i);
    rd(8'h14, 32'h12ab);
    rd(8'h08, 32'h80, 32'h80);
    chk(launches, 32'h1);
    wr(8'h00, 32'h2);
    rd(8'h14, 32'hbeef);
  endtask

  task automatic t_ecc;
    logic [15:0] ex [8] = '{16'h5a7f, 16'h1234, 16'h1111, 16'h2222, 16'h3333, 16'h4444, 0, 0};
    ev({1'b1, 1'b1, 1'b0, 23'h7f_1234, 8'h5a, 64'h4444_3333_2222_1111});
    ev({1'b1, 1'b0, 1'b0, 23'h00_0001, 8'h00, 64'h0});
    wr(8'h1c, 32'hffff);
    rd(8'h20, 32'h2);
    for (int i = 0; i < 8; i++) begin
      wr(8'h04, 32'(i));
      rd(8'h1c, ex[i]);
    end
    wr(8'h20, 32'h3);
    ev({1'b1, 1'b0, 1'b1, 23'h10_0010, 8'hff, 64'habcd});
    rd(8'h20, 32'h5);
    wr(8'h04, 32'h0);
    rd(8'h1c, 32'h3f10);
    wr(8'h04, 32'h2);
    rd(8'h1c, 32'habcd);
    wr(8'h04, 32'h3);
    rd(8'h1c, 32'h0);
  endtask

  task automatic t_prot;
    rd(8'h10, 32'h82);
    pq(1'b0, 23'h10_0000, 1'b0);
    pq(1'b1, 23'h10_0000, 1'b0);
    wr(8'h10, 32'h05);
    wr(8'h10, 32'h83);
    rd(8'h10, 32'h05);
    pq(1'b0, 23'h10_05ff, 1'b1);
    pq(1'b0, 23'h10_0600, 1'b0);
    pq(1'b0, 23'h10_2000, 1'b0);
    pq(1'b1, 23'h10_1000, 1'b1);
    rd(8'h08, 32'h20, 32'h20);
    wr(8'h08, 32'h20);
    rd(8'h08, 32'h0, 32'h20);
    do_reset(8'h80, 1'b1);
    rd(8'h10, 32'h1f);
  endtask

  // Whole run; the limit is far above the few hundred cycles needed
  initial begin
    do_reset(8'h82, 1'b0);
    t_cmd;
    t_ecc;
    t_prot;
    give_verdict;
  end

  initial begin
    repeat (4000) @(posedge clk_i);
    fails++;
    $display("Error at %0t: watchdog expired", $time);
    give_verdict;
  end
endmodule
